// *** rtl/ddr2_init_pkg.sv ***
/*
 package of constants and types for the ddr2 power-up and mode programming controller.
 assumes a 200 MHz controller clock that also paces the memory command bus.
*/
// Functional notes
// - bursts are four or eight beats only
// - hold clock enable and termination low
// - wait 200 us, then nop and raise cke
// - 400 ns of nop, then precharge all
// - program extended register 2 then 3
// - extended register 1 with dll enabled
// - mode register write with dll reset
// - precharge all, then two auto refreshes
// - mode register again without dll reset
// - calibration default then exit after 200 clocks
// - every field resupplied on each write
// - mode write encoding all strobes low
// - mode writes only when all precharged
// - wait mode set cycle time after writes
// - test mode bit kept low
// - write recovery rounded up in cycles
// - 200 clocks before any read after reset
package ddr2_init_pkg;
	localparam int CLK_PERIOD_PS = 5000;
	localparam int POWER_WAIT_US = 200;
	localparam int POWER_WAIT_CYC = (POWER_WAIT_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int CKE_WAIT_NS = 400;
	localparam int CKE_WAIT_CYC = (CKE_WAIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int MRD_CYC = 2;
	localparam int RP_CYC = 4;
	localparam int RFC_CYC = 26;
	localparam int DLL_LOCK_CYC = 200;
	localparam int REFRESH_COUNT = 2;
	localparam int WR_TIME_PS = 15000;
	localparam int WR_CYC = (WR_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	// bank select codes
	localparam logic [1:0] BANK_MR = 2'h0;
	localparam logic [1:0] BANK_EMR1 = 2'h1;
	localparam logic [1:0] BANK_EMR2 = 2'h2;
	localparam logic [1:0] BANK_EMR3 = 2'h3;
	// mode register field positions
	localparam int MR_BL_LSB = 0;
	localparam int MR_BT_BIT = 3;
	localparam int MR_CL_LSB = 4;
	localparam int MR_TM_BIT = 7;
	localparam int MR_DLLRST_BIT = 8;
	localparam int MR_WR_LSB = 9;
	localparam logic [2:0] BL4_CODE = 3'h2;
	localparam logic [2:0] BL8_CODE = 3'h3;
	// extended register 1 field positions
	localparam int E1_DLLDIS_BIT = 0;
	localparam int E1_HALF_BIT = 1;
	localparam int E1_RTT0_BIT = 2;
	localparam int E1_AL_LSB = 3;
	localparam int E1_RTT1_BIT = 6;
	localparam int E1_OCD_LSB = 7;
	localparam int E1_DQSDIS_BIT = 10;
	localparam logic [2:0] OCD_DEFAULT = 3'h7;
	localparam logic [2:0] OCD_EXIT = 3'h0;
	// command encodings {cs_n, ras_n, cas_n, we_n}
	localparam logic [3:0] CMD_NOP = 4'h7;
	localparam logic [3:0] CMD_DESEL = 4'h8;
	localparam logic [3:0] CMD_MRS = 4'h0;
	localparam logic [3:0] CMD_REF = 4'h1;
	localparam logic [3:0] CMD_PRE = 4'h2;
	localparam logic [3:0] CMD_ACT = 4'h3;
	localparam int PRE_ALL_BIT = 10;

	typedef struct packed {
		logic cke;
		logic odt;
		logic [3:0] cmd;
		logic [1:0] bank;
		logic [12:0] addr;
	} ddr_cmd_t;

	typedef struct packed {
		logic burst8;
		logic burstInterleave;
		logic [2:0] casLatency;
		logic [2:0] addLatency;
		logic halfDrive;
		logic [1:0] rtt;
		logic strobeDisable;
	} mode_cfg_t;

	typedef enum logic [12:0] {
		S_POWER = 13'h0001,
		S_CKE = 13'h0002,
		S_PREA1 = 13'h0004,
		S_EMR2 = 13'h0008,
		S_EMR3 = 13'h0010,
		S_EMR1 = 13'h0020,
		S_MRRST = 13'h0040,
		S_PREA2 = 13'h0080,
		S_REFR = 13'h0100,
		S_MRRUN = 13'h0200,
		S_OCDDEF = 13'h0400,
		S_OCDEXIT = 13'h0800,
		S_READY = 13'h1000
	} init_state_t;
endpackage

// *** rtl/ddr2_init_ctrl.sv ***
/*
 ddr2 power-up sequencer: drives the memory command bus from reset to ready.
 assumes the memory clock is derived from clk, one command per clk cycle,
 and that the user holds cfg stable from start until ready.
*/
`timescale 1ns/100ps
`default_nettype none
module ddr2_init_ctrl
	import ddr2_init_pkg::*;
#(
	parameter int POWER_WAIT = POWER_WAIT_CYC
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic start,
	input var mode_cfg_t cfg,
	output var ddr_cmd_t ddr,
	output logic busy,
	output logic ready,
	output logic readOk
);
	typedef struct packed {
		init_state_t state;
		logic [15:0] delay;
		logic [7:0] lock;
		logic [1:0] refs;
		logic issued;
		ddr_cmd_t out;
	} core_t;

	core_t cur;
	core_t next_cur;

	function automatic logic [12:0] mrWord(input mode_cfg_t c, input logic dllReset);
		logic [12:0] w;
		w = '0;
		w[MR_BL_LSB +: 3] = c.burst8 ? BL8_CODE : BL4_CODE;
		w[MR_BT_BIT] = c.burstInterleave;
		w[MR_CL_LSB +: 3] = c.casLatency;
		w[MR_TM_BIT] = 1'b0;
		w[MR_DLLRST_BIT] = dllReset;
		w[MR_WR_LSB +: 3] = 3'(WR_CYC - 1);
		return w;
	endfunction

	function automatic logic [12:0] emr1Word(input mode_cfg_t c, input logic [2:0] ocd);
		logic [12:0] w;
		w = '0;
		w[E1_DLLDIS_BIT] = 1'b0;
		w[E1_HALF_BIT] = c.halfDrive;
		w[E1_RTT0_BIT] = c.rtt[0];
		w[E1_AL_LSB +: 3] = c.addLatency;
		w[E1_RTT1_BIT] = c.rtt[1];
		w[E1_OCD_LSB +: 3] = ocd;
		w[E1_DQSDIS_BIT] = c.strobeDisable;
		return w;
	endfunction

	// ==============================================================
	// sequencer
	always_comb begin
		next_cur = cur;
		next_cur.out.cmd = CMD_NOP;
		next_cur.out.bank = '0;
		next_cur.out.addr = '0;
		if (cur.delay != '0) begin
			next_cur.delay = cur.delay - 16'h0001;
		end
		if (cur.lock != '0) begin
			next_cur.lock = cur.lock - 8'h01;
		end
		if (cur.delay == '0) begin
			case (cur.state)
				S_POWER: begin
					if (!cur.issued && start) begin
						next_cur.issued = 1'b1;
						next_cur.delay = 16'(POWER_WAIT - 1);
					end else if (cur.issued) begin
						next_cur.out.cke = 1'b1;
						next_cur.state = S_CKE;
						next_cur.delay = 16'(CKE_WAIT_CYC - 1);
					end
				end
				S_CKE: begin
					next_cur.out.cmd = CMD_PRE;
					next_cur.out.addr[PRE_ALL_BIT] = 1'b1;
					next_cur.state = S_EMR2;
					next_cur.delay = 16'(RP_CYC - 1);
				end
				S_EMR2: begin
					next_cur.out.cmd = CMD_MRS;
					next_cur.out.bank = BANK_EMR2;
					next_cur.state = S_EMR3;
					next_cur.delay = 16'(MRD_CYC - 1);
				end
				S_EMR3: begin
					next_cur.out.cmd = CMD_MRS;
					next_cur.out.bank = BANK_EMR3;
					next_cur.state = S_EMR1;
					next_cur.delay = 16'(MRD_CYC - 1);
				end
				S_EMR1: begin
					next_cur.out.cmd = CMD_MRS;
					next_cur.out.bank = BANK_EMR1;
					next_cur.out.addr = emr1Word(cfg, OCD_EXIT);
					next_cur.state = S_MRRST;
					next_cur.delay = 16'(MRD_CYC - 1);
				end
				S_MRRST: begin
					next_cur.out.cmd = CMD_MRS;
					next_cur.out.bank = BANK_MR;
					next_cur.out.addr = mrWord(cfg, 1'b1);
					next_cur.lock = 8'(DLL_LOCK_CYC);
					next_cur.state = S_PREA2;
					next_cur.delay = 16'(MRD_CYC - 1);
				end
				S_PREA2: begin
					next_cur.out.cmd = CMD_PRE;
					next_cur.out.addr[PRE_ALL_BIT] = 1'b1;
					next_cur.refs = '0;
					next_cur.state = S_REFR;
					next_cur.delay = 16'(RP_CYC - 1);
				end
				S_REFR: begin
					next_cur.out.cmd = CMD_REF;
					next_cur.refs = cur.refs + 2'h1;
					next_cur.delay = 16'(RFC_CYC - 1);
					if (cur.refs == 2'(REFRESH_COUNT - 1)) begin
						next_cur.state = S_MRRUN;
					end
				end
				S_MRRUN: begin
					next_cur.out.cmd = CMD_MRS;
					next_cur.out.bank = BANK_MR;
					next_cur.out.addr = mrWord(cfg, 1'b0);
					next_cur.state = S_OCDDEF;
					next_cur.delay = 16'(MRD_CYC - 1);
				end
				S_OCDDEF: begin
					if (cur.lock == '0) begin
						next_cur.out.cmd = CMD_MRS;
						next_cur.out.bank = BANK_EMR1;
						next_cur.out.addr = emr1Word(cfg, OCD_DEFAULT);
						next_cur.state = S_OCDEXIT;
						next_cur.delay = 16'(MRD_CYC - 1);
					end
				end
				S_OCDEXIT: begin
					next_cur.out.cmd = CMD_MRS;
					next_cur.out.bank = BANK_EMR1;
					next_cur.out.addr = emr1Word(cfg, OCD_EXIT);
					next_cur.state = S_READY;
					next_cur.delay = 16'(MRD_CYC - 1);
				end
				S_READY: begin
				end
				default: begin
					next_cur.state = S_POWER;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cur.state <= S_POWER;
			cur.delay <= '0;
			cur.lock <= '0;
			cur.refs <= '0;
			cur.issued <= 1'b0;
			cur.out.cke <= 1'b0;
			cur.out.odt <= 1'b0;
			cur.out.cmd <= CMD_NOP;
			cur.out.bank <= '0;
			cur.out.addr <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	assign ddr = cur.out;
	assign busy = cur.state != S_READY;
	assign ready = (cur.state == S_READY) && (cur.delay == '0);
	assign readOk = ready && (cur.lock == '0);

	// ==============================================================
	// checks
	a_odt_low: assert property (@(posedge clk) disable iff (!rstn)
		!cur.out.odt) else $error("odt raised during init");
	a_cke_early: assert property (@(posedge clk) disable iff (!rstn)
		(cur.state == S_POWER) |-> !cur.out.cke) else $error("cke high too early");
	a_cke_nop: assert property (@(posedge clk) disable iff (!rstn)
		$rose(cur.out.cke) |-> cur.out.cmd == CMD_NOP) else $error("cke rose with command");
	a_pre_gap: assert property (@(posedge clk) disable iff (!rstn)
		$rose(cur.out.cke) |-> (cur.out.cmd == CMD_NOP) [*8]) else $error("command inside cke wait");
	a_mrs_cke: assert property (@(posedge clk) disable iff (!rstn)
		(cur.out.cmd == CMD_MRS) |-> cur.out.cke) else $error("mode write with cke low");
	a_test_bit: assert property (@(posedge clk) disable iff (!rstn)
		(cur.out.cmd == CMD_MRS && cur.out.bank == BANK_MR) |-> !cur.out.addr[MR_TM_BIT])
		else $error("test mode bit set");
	a_mrd_gap: assert property (@(posedge clk) disable iff (!rstn)
		(cur.out.cmd == CMD_MRS) |=> cur.out.cmd == CMD_NOP) else $error("mode set cycle violated");
	a_dll_on: assert property (@(posedge clk) disable iff (!rstn)
		(cur.out.cmd == CMD_MRS && cur.out.bank == BANK_EMR1) |-> !cur.out.addr[E1_DLLDIS_BIT])
		else $error("dll disabled");
	a_ocd_lock: assert property (@(posedge clk) disable iff (!rstn)
		(cur.out.cmd == CMD_MRS && cur.out.addr[E1_OCD_LSB +: 3] == OCD_DEFAULT
		&& cur.out.bank == BANK_EMR1) |-> $past(cur.lock) == '0) else $error("calibration too early");
	a_no_act: assert property (@(posedge clk) disable iff (!rstn)
		busy |-> cur.out.cmd != CMD_ACT) else $error("activate during init");
	c_cke_up: cover property (@(posedge clk) disable iff (!rstn) $rose(cur.out.cke));
	c_refresh: cover property (@(posedge clk) disable iff (!rstn) cur.out.cmd == CMD_REF);
	c_ocd: cover property (@(posedge clk) disable iff (!rstn) cur.state == S_OCDEXIT);
	c_ready: cover property (@(posedge clk) disable iff (!rstn) $rose(readOk));
endmodule
`default_nettype wire

// *** tb/ddr2_dev_model.sv ***
/*
 behavioural memory device: decodes the command bus and keeps its mode registers.
 assumes commands are sampled at the rising edge of clk, one per cycle.
*/
`timescale 1ns/100ps
`default_nettype none
module ddr2_dev_model
	import ddr2_init_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input var ddr_cmd_t ddr,
	output logic [12:0] mr,
	output logic [12:0] emr1,
	output int refCnt
);
	logic [12:0] emr2, emr3, openRow;
	logic [1:0] openBank;
	logic rowOpen, dllOn;
	// ==========================================
	// command decode, array never touched by mode writes
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			refCnt <= 0;
			rowOpen <= 1'b0;
			dllOn <= 1'b0;
		end else if (ddr.cke === 1'b1) begin
			case (ddr.cmd)
				CMD_ACT: begin
					openBank <= ddr.bank;
					openRow <= ddr.addr;
					rowOpen <= 1'b1;
				end
				CMD_PRE: if (ddr.addr[PRE_ALL_BIT]) rowOpen <= 1'b0;
				CMD_REF: refCnt <= refCnt + 1;
				CMD_MRS: if (!rowOpen) begin
					case (ddr.bank)
						BANK_MR: mr <= ddr.addr;
						BANK_EMR1: begin
							emr1 <= ddr.addr;
							dllOn <= !ddr.addr[E1_DLLDIS_BIT];
						end
						BANK_EMR2: emr2 <= ddr.addr;
						default: emr3 <= ddr.addr;
					endcase
				end
				default: ;
			endcase
		end
	end
endmodule
`default_nettype wire

// *** tb/tb.sv ***
/*
 self-checking bench for the power-up sequencer with a device model on the bus.
 assumes a short power wait parameter and a 5 ns clock.
*/
`timescale 1ns/100ps
`default_nettype none
module tb;
	import ddr2_init_pkg::*;
	localparam int PW = 20;
	logic clk, rstn, start, busy, ready, readOk;
	mode_cfg_t cfg;
	ddr_cmd_t ddr;
	logic [12:0] mr, emr1;
	int refCnt, n_errors, checks_done, cyc, ckeCyc;
	int logCyc[$];
	ddr_cmd_t logCmd[$];
	ddr2_init_ctrl #(.POWER_WAIT(PW)) dut (.clk(clk), .rstn(rstn), .start(start), .cfg(cfg),
		.ddr(ddr), .busy(busy), .ready(ready), .readOk(readOk));
	ddr2_dev_model model (.clk(clk), .rstn(rstn), .ddr(ddr), .mr(mr), .emr1(emr1), .refCnt(refCnt));
	// ==========================================
	// bus monitor
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (ddr.cke === 1'b1 && ckeCyc < 0) ckeCyc <= cyc;
		if (ddr.cmd[3] === 1'b0 && ddr.cmd !== CMD_NOP) begin
			logCyc.push_back(cyc);
			logCmd.push_back(ddr);
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	function automatic logic [12:0] mrAddr(input mode_cfg_t c, input logic rst);
		return {1'b0, 3'(WR_CYC - 1), rst, 1'b0, c.casLatency, c.burstInterleave,
			c.burst8 ? BL8_CODE : BL4_CODE};
	endfunction
	function automatic logic [12:0] e1Addr(input mode_cfg_t c, input logic [2:0] ocd);
		return {2'h0, c.strobeDisable, ocd, c.rtt[1], c.addLatency, c.rtt[0], c.halfDrive, 1'b0};
	endfunction
	// ==========================================
	// scenarios
	task automatic do_reset();
		rstn <= 1'b0;
		repeat (5) @(posedge clk);
		check({ddr.cke, ddr.odt, ddr.cmd, busy, ready}, {2'h0, CMD_NOP, 2'h2});
		logCyc.delete();
		logCmd.delete();
		ckeCyc = -1;
		rstn <= 1'b1;
		@(posedge clk);
	endtask
	task automatic t_run(input mode_cfg_t c);
		logic [3:0] eCmd[11] = '{CMD_PRE, CMD_MRS, CMD_MRS, CMD_MRS, CMD_MRS, CMD_PRE,
			CMD_REF, CMD_REF, CMD_MRS, CMD_MRS, CMD_MRS};
		logic [1:0] eBank[11] = '{2'h0, BANK_EMR2, BANK_EMR3, BANK_EMR1, BANK_MR, 2'h0,
			2'h0, 2'h0, BANK_MR, BANK_EMR1, BANK_EMR1};
		int eGap[11] = '{CKE_WAIT_CYC, RP_CYC, MRD_CYC, MRD_CYC, MRD_CYC, MRD_CYC,
			RP_CYC, RFC_CYC, RFC_CYC, 0, MRD_CYC};
		int t0;
		cfg <= c;
		start <= 1'b1;
		t0 = cyc;
		for (int i = 0; i < 3000 && ready !== 1'b1; i++) @(posedge clk);
		start <= 1'b0;
		@(posedge clk);
		check((ckeCyc - t0 >= PW + 1) && (ckeCyc - t0 <= PW + 3), 1);
		check(logCmd.size(), 11);
		if (logCmd.size() != 11) return;
		for (int i = 0; i < 11; i++) begin
			check(logCmd[i].cmd, eCmd[i]);
			if (eCmd[i] == CMD_MRS) check(logCmd[i].bank, eBank[i]);
			if (eCmd[i] == CMD_PRE) check(logCmd[i].addr[PRE_ALL_BIT], 1);
			if (i != 9) check(logCyc[i] - (i == 0 ? ckeCyc : logCyc[i - 1]), eGap[i]);
		end
		check(logCmd[3].addr, e1Addr(c, OCD_EXIT));
		check(logCmd[4].addr, mrAddr(c, 1'b1));
		check(logCmd[8].addr, mrAddr(c, 1'b0));
		check(logCmd[9].addr, e1Addr(c, OCD_DEFAULT));
		check(logCmd[10].addr, e1Addr(c, OCD_EXIT));
		check(logCyc[9] - logCyc[4] >= DLL_LOCK_CYC, 1);
		check({ready, readOk, busy, ddr.cke, ddr.odt}, 5'h1a);
		check({mr, emr1}, {mrAddr(c, 1'b0), e1Addr(c, OCD_EXIT)});
		check(refCnt, REFRESH_COUNT);
		$display("test run done");
	endtask
	task automatic t_refused();
		start <= 1'b1;
		repeat (40) @(posedge clk);
		start <= 1'b0;
		check(logCmd.size(), 11);
		check({ready, ddr.cke}, 2'h3);
		$display("test restart ignored done");
	endtask
	task automatic t_mid_reset(input mode_cfg_t c);
		do_reset();
		start <= 1'b1;
		repeat (30) @(posedge clk);
		start <= 1'b0;
		check(ddr.cke, 1'b1);
		do_reset();
		t_run(c);
		$display("test mid reset done");
	endtask
	// ==========================================
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial begin
		#100000;
		n_errors++;
		stop_test();
	end
	initial begin
		rstn = 1'b0;
		start = 1'b0;
		cfg = '0;
		cyc = 0;
		ckeCyc = -1;
		n_errors = 0;
		checks_done = 0;
		do_reset();
		t_run('{1'b1, 1'b0, 3'h4, 3'h0, 1'b0, 2'h1, 1'b0});
		t_refused();
		t_mid_reset('{1'b0, 1'b1, 3'h5, 3'h3, 1'b1, 2'h2, 1'b1});
		stop_test();
	end
endmodule
`default_nettype wire
